// ==== rtl/qdac_pkg.sv ====
// constants, field layout and channel type for the quad converter update logic
// assumes a 100 MHz core clock and a serial clock from the host
// Function
// RULE_01: load strobe copies input registers into dac registers
// RULE_02: synchronous mode updates at sixteenth falling edge
// RULE_03: input writes leave outputs alone without strobe
// RULE_04: strobe falling edge loads dac registers
// RULE_05: power-down pin low powers down, high normal
// RULE_06: outputs three-state during power-down
// RULE_07: power-down keeps every register content
// RULE_08: writes and loads still work in power-down
// RULE_09: outputs resume from dac codes after exit delay
// RULE_10: host holds frame select low whole word
// RULE_11: byte hosts keep frame low across two bytes
// RULE_12: host sends most significant bit first
// RULE_13: host data valid at falling clock edge
// RULE_14: dsp host changes data on rising edges
// RULE_15: word carries channel, gain, buffer, code fields
// RULE_16: early frame rise discards the word
// RULE_17: strobe loads only channels written since update
// RULE_18: clear zeroes input and dac registers
// RULE_19: async pins synchronised before register transfers
// RULE_20: strobe low at completion transfers new word
package qdac_pkg;
	// serial word layout
	localparam int                 WORD_BITS = 16;
	localparam int                 CH_COUNT  = 4;
	localparam int                 CODE_BITS = 12;
	localparam int                 CH_HI     = 15;
	localparam int                 CH_LO     = 14;
	localparam int                 GAIN_BIT  = 13;
	localparam int                 BUF_BIT   = 12;
	localparam int                 CODE_HI   = 11;
	localparam int                 CNT_BITS  = 5;
	localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_BITS-1:0] CNT_ONE  = 5'h01;
	localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h0f;
	localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;

	// power-down exit timing
	localparam real CLK_MHZ      = 100.0;
	localparam real EXIT_5V_US   = 2.5;
	localparam real EXIT_3V_US   = 5.0;
	localparam int  EXIT_5V_CYC  = int'(EXIT_5V_US * CLK_MHZ);
	localparam int  EXIT_3V_CYC  = int'(EXIT_3V_US * CLK_MHZ);
	localparam int  EXIT_BITS    = 10;
	localparam logic [EXIT_BITS-1:0] EXIT_5V_CNT = EXIT_BITS'(EXIT_5V_CYC);
	localparam logic [EXIT_BITS-1:0] EXIT_3V_CNT = EXIT_BITS'(EXIT_3V_CYC);
	localparam logic [EXIT_BITS-1:0] EXIT_ZERO   = 10'h000;
	localparam logic [EXIT_BITS-1:0] EXIT_STEP   = 10'h001;

	// one channel: mode bits and 12-bit code from the low bits of the word
	typedef struct packed {
		logic                 gain;
		logic                 buffered;
		logic [CODE_BITS-1:0] code;
	} qdac_chan_t;

	localparam qdac_chan_t CHAN_ZERO = '{gain: 1'b0, buffered: 1'b0, code: 12'h000};
endpackage

// ==== rtl/qdac_link_if.sv ====
// carrier between the serial receiver and the update core
// word is stable between toggles of done_toggle
`timescale 1ns/1ps
interface qdac_link_if;
	logic [15:0] word;
	logic        done_toggle;

	modport rx   (output word, output done_toggle);
	modport core (input word, input done_toggle);
endinterface

// ==== rtl/qdac_serial_rx.sv ====
// serial receiver on the host's serial clock, shifts on falling edges
// assumes frame select is low for the whole word; clock may stop between frames
`timescale 1ns/1ps
module qdac_serial_rx (
	// link pins
	input  wire logic    i_sclk,
	input  wire logic    i_sync_n,
	input  wire logic    i_sdin,
	// reset
	input  wire logic    i_reset_n,
	// carrier to the core
	qdac_link_if.rx      link
);
	typedef struct packed {
		logic [15:0] shift;
		logic [15:0] word;
		logic        tog;
	} qdac_rx_state_t;

	qdac_rx_state_t                  st;
	qdac_rx_state_t                  next_st;
	logic [qdac_pkg::CNT_BITS-1:0]   count;

	// bit counter, cleared at once when the frame ends early or normally
	always_ff @(negedge i_sclk or posedge i_sync_n or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count <= qdac_pkg::CNT_ZERO;
		end else if (i_sync_n) begin
			count <= qdac_pkg::CNT_ZERO; // [RULE_16]
		end else if (count != qdac_pkg::CNT_FULL) begin
			count <= count + qdac_pkg::CNT_ONE; // extra edges ignored
		end
	end

	// shift msb first, publish on the sixteenth falling edge
	always_comb begin
		next_st = st;
		if (!i_sync_n && count != qdac_pkg::CNT_FULL) begin
			next_st.shift = {st.shift[14:0], i_sdin}; // [RULE_15]
			if (count == qdac_pkg::CNT_LAST) begin
				next_st.word = {st.shift[14:0], i_sdin}; // [RULE_02]
				next_st.tog  = ~st.tog;
			end
		end
	end

	// state register
	always_ff @(negedge i_sclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign link.word        = st.word;
	assign link.done_toggle = st.tog;
endmodule // qdac_serial_rx

// ==== rtl/qdac_core.sv ====
// update and power-down control of a quad converter, top level
// assumes an unrelated serial clock; strobe, power-down, clear and supply pins are asynchronous
`timescale 1ns/1ps
module qdac_core (
	// core clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_reset_n,
	// serial link
	input  wire logic                          i_sclk,
	input  wire logic                          i_sync_n,
	input  wire logic                          i_sdin,
	// control pins
	input  wire logic                          i_load_strobe_n,
	input  wire logic                          i_power_down_n,
	input  wire logic                          i_clear_all_n,
	input  wire logic                          i_supply_low,
	// converter side
	output qdac_pkg::qdac_chan_t [3:0]         o_dac,
	output logic [3:0]                         o_out_enable,
	output logic [3:0]                         o_pending
);
	typedef struct packed {
		logic                                  load_strobe_n_meta;
		logic                                  load_strobe_n_sync;
		logic                                  load_strobe_n_prev;
		logic                                  pd_meta;
		logic                                  pd_sync;
		logic                                  clr_meta;
		logic                                  clr_sync;
		logic                                  low_meta;
		logic                                  low_sync;
		logic                                  tog_meta;
		logic                                  tog_sync;
		logic                                  tog_prev;
		qdac_pkg::qdac_chan_t [3:0]            inreg;
		qdac_pkg::qdac_chan_t [3:0]            dac;
		logic [3:0]                            pending;
		logic [qdac_pkg::EXIT_BITS-1:0]        exit_cnt;
		logic [3:0]                            out_en;
	} qdac_core_state_t;

	qdac_core_state_t st;
	qdac_core_state_t next_st;
	qdac_link_if      link ();

	// serial receiver on the link clock
	qdac_serial_rx u_rx (
		.i_sclk    (i_sclk),
		.i_sync_n  (i_sync_n),
		.i_sdin    (i_sdin),
		.i_reset_n (i_reset_n),
		.link      (link)
	);

	// next-state logic
	always_comb begin
		logic       word_done;
		logic       load_strobe_n_fall;
		logic [1:0] ch;
		logic [3:0] load;
		word_done = 1'b0;
		load_strobe_n_fall = 1'b0;
		ch        = 2'b00;
		load      = 4'h0;
		next_st   = st;
		// two-stage synchronisers for pins and the word toggle
		next_st.load_strobe_n_meta = i_load_strobe_n; // [RULE_19]
		next_st.load_strobe_n_sync = st.load_strobe_n_meta;
		next_st.load_strobe_n_prev = st.load_strobe_n_sync;
		next_st.pd_meta   = i_power_down_n;
		next_st.pd_sync   = st.pd_meta;
		next_st.clr_meta  = i_clear_all_n;
		next_st.clr_sync  = st.clr_meta;
		next_st.low_meta  = i_supply_low;
		next_st.low_sync  = st.low_meta;
		next_st.tog_meta  = link.done_toggle;
		next_st.tog_sync  = st.tog_meta;
		next_st.tog_prev  = st.tog_sync;
		word_done = st.tog_sync ^ st.tog_prev;
		load_strobe_n_fall = st.load_strobe_n_prev & ~st.load_strobe_n_sync;
		ch        = link.word[qdac_pkg::CH_HI:qdac_pkg::CH_LO];
		// completed word goes to its input register, and to its dac register too while strobe is low
		if (word_done) begin
			next_st.inreg[ch].gain     = link.word[qdac_pkg::GAIN_BIT]; // [RULE_15]
			next_st.inreg[ch].buffered = link.word[qdac_pkg::BUF_BIT];
			next_st.inreg[ch].code     = link.word[qdac_pkg::CODE_HI:0];
			next_st.pending[ch]        = 1'b1; // [RULE_03]
			if (!st.load_strobe_n_sync) begin
				load[ch] = 1'b1; // [RULE_20] [RULE_02]
			end
		end
		// falling strobe loads every channel written since its last update
		if (load_strobe_n_fall) begin
			load = load | st.pending; // [RULE_04] [RULE_17]
		end
		// transfers run regardless of power-down
		for (int i = 0; i < qdac_pkg::CH_COUNT; i++) begin
			if (load[i]) begin
				next_st.dac[i]     = next_st.inreg[i]; // [RULE_01] [RULE_08]
				next_st.pending[i] = 1'b0;
			end
		end
		// outputs three-state in power-down, resume after the exit delay
		if (!st.pd_sync) begin
			next_st.out_en   = 4'h0; // [RULE_05] [RULE_06] [RULE_07]
			next_st.exit_cnt = st.low_sync ? qdac_pkg::EXIT_3V_CNT : qdac_pkg::EXIT_5V_CNT;
		end else if (st.exit_cnt != qdac_pkg::EXIT_ZERO) begin
			next_st.exit_cnt = st.exit_cnt - qdac_pkg::EXIT_STEP;
		end else begin
			next_st.out_en = 4'hf; // [RULE_09]
		end
		// clear forces input and dac registers and pending flags to zero
		if (!st.clr_sync) begin
			for (int i = 0; i < qdac_pkg::CH_COUNT; i++) begin
				next_st.inreg[i] = qdac_pkg::CHAN_ZERO; // [RULE_18]
				next_st.dac[i]   = qdac_pkg::CHAN_ZERO;
			end
			next_st.pending = 4'h0;
		end
	end

	// state register, strobe and clear pins idle high after reset, power-down and supply low
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st           <= '0;
			st.load_strobe_n_meta <= 1'b1;
			st.load_strobe_n_sync <= 1'b1;
			st.load_strobe_n_prev <= 1'b1;
			st.clr_meta  <= 1'b1;
			st.clr_sync  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign o_dac        = st.dac;
	assign o_out_enable = st.out_en;
	assign o_pending    = st.pending;
endmodule // qdac_core

// ==== testbench/qdac_core_properties.sv ====
// checker on the pins of the converter update core
// assumes a bind onto qdac_core, one clock domain
`timescale 1ns/1ps
module qdac_core_properties (
	// clock and reset
	input wire logic                       i_clk,
	input wire logic                       i_reset_n,
	// control pins
	input wire logic                       i_load_strobe_n,
	input wire logic                       i_power_down_n,
	input wire logic                       i_clear_all_n,
	input wire logic                       i_supply_low,
	// converter side
	input wire qdac_pkg::qdac_chan_t [3:0] o_dac,
	input wire logic [3:0]                 o_out_enable,
	input wire logic [3:0]                 o_pending
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic [9:0] hi_cnt;
	// cycles power-down pin stayed high, saturating
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) hi_cnt <= 10'h3ff;
		else if (!i_power_down_n) hi_cnt <= 10'h000;
		else if (hi_cnt != 10'h3ff) hi_cnt <= hi_cnt + 10'h001;
	end
	property p_off; !i_power_down_n [*4] |-> o_out_enable == 4'h0; endproperty
	a_off: assert property (p_off) else $error("output on in power-down");
	property p_same; o_out_enable == 4'h0 || o_out_enable == 4'hf; endproperty
	a_same: assert property (p_same) else $error("channels differ in power state");
	property p_early; $rose(o_out_enable[0]) |-> hi_cnt >= (i_supply_low ? 10'h1f4 : 10'h0fa); endproperty
	a_early: assert property (p_early) else $error("output back too soon");
	property p_late; hi_cnt == (i_supply_low ? 10'h208 : 10'h10e) |-> o_out_enable == 4'hf; endproperty
	a_late: assert property (p_late) else $error("output back too late");
	property p_clr; !i_clear_all_n [*4] |-> o_dac == '0 && o_pending == 4'h0; endproperty
	a_clr: assert property (p_clr) else $error("clear left data");
	property p_hold; (i_load_strobe_n && i_clear_all_n) [*4] |=> $stable(o_dac); endproperty
	a_hold: assert property (p_hold) else $error("dac moved without strobe");
	property p_low; !i_load_strobe_n [*5] |-> o_pending == 4'h0; endproperty
	a_low: assert property (p_low) else $error("pending under low strobe");
	property p_wr; $rose(o_pending[3]) |-> $stable(o_dac[3]); endproperty
	a_wr: assert property (p_wr) else $error("write moved dac");
endmodule // qdac_core_properties
bind qdac_core qdac_core_properties u_props (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_load_strobe_n(i_load_strobe_n), .i_power_down_n(i_power_down_n), .i_clear_all_n(i_clear_all_n),
	.i_supply_low(i_supply_low), .o_dac(o_dac), .o_out_enable(o_out_enable), .o_pending(o_pending));

// ==== testbench/qdac_host_model.sv ====
// host model driving the three-wire link
// assumes send is called from one process at a time
`timescale 1ns/1ps
module qdac_host_model (
	// link pins
	output logic o_sclk,
	output logic o_sync_n,
	output logic o_sdin
);
	// idle link, clock still between frames
	initial begin
		o_sclk = 1'b0;
		o_sync_n = 1'b1;
		o_sdin = 1'b0;
	end
	// n bits msb first, 30 ns clock, gap as between two bytes
	task automatic send(input logic [15:0] w, input int n);
		#3.3 o_sync_n = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			if (i == 7) #40;
			#15 o_sclk = 1'b1;
			o_sdin = w[i];
			#15 o_sclk = 1'b0;
		end
		#15 o_sync_n = 1'b1;
		o_sdin = ~o_sdin;
	endtask
endmodule // qdac_host_model

// ==== testbench/quad_dac_load_powerdown_ctrl_bench.sv ====
// self-checking bench for the converter update core
// assumes the host model drives the link
`timescale 1ns/1ps
module quad_dac_load_powerdown_ctrl_bench;
	logic                       i_clk = 1'b0;
	logic                       i_reset_n = 1'b0;
	logic                       i_load_strobe_n = 1'b1;
	logic                       i_power_down_n = 1'b1;
	logic                       i_clear_all_n = 1'b1;
	logic                       i_supply_low = 1'b0;
	logic                       sclk, sync_n, sdin;
	logic [3:0]                 o_out_enable, o_pending, pend;
	qdac_pkg::qdac_chan_t [3:0] o_dac, model, inreg;
	int                         mismatches = 0;
	int                         checks = 0;
	always #5 i_clk = ~i_clk;
	qdac_host_model host (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));
	qdac_core dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdin(sdin),
		.i_load_strobe_n(i_load_strobe_n), .i_power_down_n(i_power_down_n), .i_clear_all_n(i_clear_all_n),
		.i_supply_low(i_supply_low), .o_dac(o_dac), .o_out_enable(o_out_enable), .o_pending(o_pending));
	// expected fields of a word
	function automatic qdac_pkg::qdac_chan_t chan_of(input logic [15:0] v);
		return '{gain: v[13], buffered: v[12], code: v[11:0]};
	endfunction
	// compare and count
	task automatic check(input string name, input logic [55:0] seen, input logic [55:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// wait edges, land just after the last
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic check_all();
		check("dac", o_dac, model);
		check("pending", 56'(o_pending), 56'(pend));
	endtask
	// random frame of n bits to a channel
	task automatic send(input int ch, input int n);
		logic [15:0] w;
		w = {2'(ch), 14'($urandom)};
		host.send(w, n);
		tick(6);
		if (n == 16) begin
			inreg[ch] = chan_of(w);
			if (i_load_strobe_n) pend[ch] = 1'b1;
			else model[ch] = inreg[ch];
		end
		check_all();
	endtask
	// strobe pulse, pending channels move
	task automatic load();
		i_load_strobe_n <= 1'b0;
		tick(4);
		i_load_strobe_n <= 1'b1;
		tick(4);
		for (int c = 0; c < 4; c++) if (pend[c]) model[c] = inreg[c];
		pend = 4'h0;
		check_all();
	endtask
	// main sequence
	initial begin
		void'($urandom(32'hc6cd));
		model = '0;
		inreg = '0;
		pend = 4'h0;
		tick(10);
		i_reset_n <= 1'b1;
		tick(5);
		check("enable", 56'(o_out_enable), 56'h0);
		// power-down sync resets low, so the exit delay also runs after reset
		tick(260);
		check("enable", 56'(o_out_enable), 56'hf);
		for (int c = 3; c >= 0; c--) send(c, 16);
		load();
		send(2, 10);
		load();
		i_load_strobe_n <= 1'b0;
		tick(4);
		repeat (4) send($urandom % 4, 16);
		i_load_strobe_n <= 1'b1;
		i_power_down_n <= 1'b0;
		tick(6);
		check("enable", 56'(o_out_enable), 56'h0);
		send(0, 16);
		load();
		for (int s = 0; s < 2; s++) begin
			i_supply_low <= 1'(s);
			// supply level settles before the exit count is armed
			tick(4);
			i_power_down_n <= 1'b1;
			tick(230 + 250 * s);
			check("enable", 56'(o_out_enable), 56'h0);
			tick(40);
			check("enable", 56'(o_out_enable), 56'hf);
			i_power_down_n <= 1'b0;
			tick(6);
		end
		i_power_down_n <= 1'b1;
		send(1, 16);
		i_clear_all_n <= 1'b0;
		tick(6);
		model = '0;
		inreg = '0;
		pend = 4'h0;
		check_all();
		i_clear_all_n <= 1'b1;
		tick(3);
		repeat (20) begin
			send($urandom % 4, ($urandom % 4 == 0) ? 10 : 16);
			if ($urandom % 2) load();
		end
		finish_test();
	end
	// watchdog against a hang
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule // quad_dac_load_powerdown_ctrl_bench
